/* verilog/smb_core.v */
`timescale 1ns/1ps
`include "smb_map.vh"
module smb_core
(
  // Clock and reset
  input  wire       ref_clk_in,
  input  wire       rst_in,
  // Special function register port
  input  wire [7:0] sfr_addr_in,
  input  wire       sfr_wr_in,
  input  wire [7:0] sfr_wdata_in,
  output reg  [7:0] sfr_rdata_out,
  // Two-wire bus pins, open drain
  input  wire       scl_in,
  output wire       scl_drv_out,
  output wire       scl_oe_n_out,
  input  wire       sda_in,
  output wire       sda_drv_out,
  output wire       sda_oe_n_out,
  // Event flag and low-timeout timer steering
  output wire       si_flag_out,
  output reg        t3_reload_out,
  output reg        t3_count_out
);

  // Byte phases
  localparam [2:0] PH_IDLE = 3'd0;
  localparam [2:0] PH_ADDR = 3'd1;
  localparam [2:0] PH_SRX  = 3'd2;
  localparam [2:0] PH_STX  = 3'd3;
  localparam [2:0] PH_MTX  = 3'd4;
  localparam [2:0] PH_MRX  = 3'd5;
  localparam [2:0] PH_LOST = 3'd6;
  // Master sequencer states
  localparam [2:0] M_NONE  = 3'd0;
  localparam [2:0] M_START = 3'd1;
  localparam [2:0] M_BYTE  = 3'd2;
  localparam [2:0] M_WAIT  = 3'd3;
  localparam [2:0] M_STOP  = 3'd4;
  localparam [2:0] M_RST   = 3'd5;

  reg  [1:0] scl_sy_r;
  reg  [1:0] sda_sy_r;
  reg        scl_d_r;
  reg        sda_d_r;
  reg        en_r;
  reg        sta_r;
  reg        sto_r;
  reg        si_r;
  reg        aa_r;
  reg        fte_r;
  reg        toe_r;
  reg        busy_r;
  reg  [7:0] own_r;
  reg  [7:0] rate_r;
  reg  [7:0] dat_r;
  reg  [7:0] stat_r;
  reg  [2:0] ph_r;
  reg  [2:0] mst_r;
  reg  [3:0] bcnt_r;
  reg        ack_r;
  reg        gc_r;
  reg        lost_r;
  reg        first_r;
  reg        mas_r;
  reg        msl_r;
  reg        msda_r;
  reg        dlow_r;
  reg  [7:0] tmr_r;
  reg        scl_low_r;
  reg        sda_low_r;

  // Bus view after the two-stage synchronisers
  wire scl_s     = scl_sy_r[1];
  wire sda_s     = sda_sy_r[1];
  wire scl_rise  = scl_s & ~scl_d_r;
  wire scl_fall  = ~scl_s & scl_d_r;
  wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  // Register write strobes
  wire wr_ctl  = sfr_wr_in & (sfr_addr_in == `SMB_ADR_CTRL);
  wire wr_own  = sfr_wr_in & (sfr_addr_in == `SMB_ADR_OWN);
  wire wr_rate = sfr_wr_in & (sfr_addr_in == `SMB_ADR_RATE);
  wire wr_dat  = sfr_wr_in & (sfr_addr_in == `SMB_ADR_DATA);
  wire si_clr  = wr_ctl & si_r & ~sfr_wdata_in[`SMB_CTL_SI];

  // Address match: own address is compared on bits 7 to 1 at once, zero never matches as own
  wire own_hit = (dat_r[7:1] == own_r[7:1]) & (|dat_r[7:1]);
  wire gc_hit  = (dat_r == `SMB_GC_ADDR) & own_r[0];
  wire tx_ph   = (ph_r == PH_STX) | (ph_r == PH_MTX);

  // Shared rate timer: master half periods, or bus-free detect when idle
  wire tmr_ovf = (tmr_r == 8'hff);
  wire mact    = (mst_r != M_NONE);
  wire tmr_ld  = tmr_ovf | (mact ? ((mst_r == M_WAIT) | (~msl_r & ~scl_s))
                                 : (~scl_s | ~fte_r | ~busy_r));

  assign scl_drv_out  = 1'b0;
  assign sda_drv_out  = 1'b0;
  assign scl_oe_n_out = ~scl_low_r;
  assign sda_oe_n_out = ~sda_low_r;
  assign si_flag_out  = si_r;

  // Pin synchronisers; only the second stage feeds logic
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      scl_sy_r <= 2'b11;
      sda_sy_r <= 2'b11;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
    end
    else
    begin
      scl_sy_r <= {scl_sy_r[0], scl_in};
      sda_sy_r <= {sda_sy_r[0], sda_in};
      scl_d_r  <= scl_s;
      sda_d_r  <= sda_s;
    end
  end

  // Rate timer counts up from the rate register to overflow
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      tmr_r <= `SMB_RST_RATE;
    else if (tmr_ld)
      tmr_r <= rate_r;
    else
      tmr_r <= tmr_r + 8'h01;
  end

  // Pin drivers and timer steering, registered so they never glitch
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      scl_low_r     <= 1'b0;
      sda_low_r     <= 1'b0;
      t3_reload_out <= 1'b0;
      t3_count_out  <= 1'b0;
    end
    else
    begin
      // Holding only latches on a low SCL; a high SCL is pulled down only by the master clock msl_r
      scl_low_r     <= en_r & ((si_r & (scl_low_r | ~scl_s)) | msl_r);
      sda_low_r     <= en_r & (dlow_r | msda_r);
      t3_reload_out <= toe_r & scl_s;
      t3_count_out  <= toe_r & ~scl_s;
    end
  end

  // Register read port, one cycle behind the address
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      sfr_rdata_out <= 8'h00;
    else
    begin
      case (sfr_addr_in)
        `SMB_ADR_CTRL: sfr_rdata_out <= {busy_r, en_r, sta_r, sto_r, si_r, aa_r, fte_r, toe_r};
        `SMB_ADR_STAT: sfr_rdata_out <= stat_r;
        `SMB_ADR_DATA: sfr_rdata_out <= dat_r;
        `SMB_ADR_OWN:  sfr_rdata_out <= own_r;
        `SMB_ADR_RATE: sfr_rdata_out <= rate_r;
        default:       sfr_rdata_out <= 8'h00;
      endcase
    end
  end

  // Control flags, shift register and bit engine; hardware sets land after
  // software writes so a flag set in a clearing cycle survives
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      {en_r, sta_r, sto_r, si_r, aa_r, fte_r, toe_r} <= 7'h00;
      busy_r  <= 1'b0;
      own_r   <= `SMB_RST_OWN;
      rate_r  <= `SMB_RST_RATE;
      dat_r   <= `SMB_RST_DATA;
      stat_r  <= `SMB_RST_STAT;
      ph_r    <= PH_IDLE;
      mst_r   <= M_NONE;
      bcnt_r  <= 4'h0;
      ack_r   <= 1'b0;
      gc_r    <= 1'b0;
      lost_r  <= 1'b0;
      first_r <= 1'b0;
      mas_r   <= 1'b0;
      msl_r   <= 1'b0;
      msda_r  <= 1'b0;
      dlow_r  <= 1'b0;
    end
    else
    begin
      if (wr_ctl)
      begin
        en_r  <= sfr_wdata_in[`SMB_CTL_EN];
        sta_r <= sfr_wdata_in[`SMB_CTL_STA];
        sto_r <= sfr_wdata_in[`SMB_CTL_STO];
        si_r  <= sfr_wdata_in[`SMB_CTL_SI];
        aa_r  <= sfr_wdata_in[`SMB_CTL_AA];
        fte_r <= sfr_wdata_in[`SMB_CTL_FTE];
        toe_r <= sfr_wdata_in[`SMB_CTL_TOE];
      end
      if (si_clr)
        stat_r <= `SMB_ST_IDLE;
      if (wr_own)
        own_r <= sfr_wdata_in;
      if (wr_rate)
        rate_r <= sfr_wdata_in;
      // Software can write the data register at any time; a bus shift in the same cycle wins
      if (wr_dat)
        dat_r <= sfr_wdata_in;
      if (!en_r)
      begin
        ph_r   <= PH_IDLE;
        mst_r  <= M_NONE;
        mas_r  <= 1'b0;
        msl_r  <= 1'b0;
        msda_r <= 1'b0;
        dlow_r <= 1'b0;
        busy_r <= 1'b0;
        bcnt_r <= 4'h0;
      end
      else
      begin
        // Bus free timeout while SCL stays high
        if (!mact && fte_r && busy_r && scl_s && tmr_ovf)
          busy_r <= 1'b0;
        if (start_det)
        begin
          busy_r <= 1'b1;
          bcnt_r <= 4'h0;
          if ((ph_r == PH_SRX) || (ph_r == PH_STX))
          begin
            si_r   <= 1'b1;
            stat_r <= `SMB_ST_SL_STOP;
          end
          if (!mas_r)
            ph_r <= PH_ADDR;
        end
        else if (stop_det)
        begin
          busy_r <= 1'b0;
          sto_r  <= 1'b0;
          if ((ph_r == PH_SRX) || (ph_r == PH_STX) || (ph_r != PH_IDLE && bcnt_r != 4'h0))
          begin
            si_r   <= 1'b1;
            stat_r <= (ph_r == PH_SRX || ph_r == PH_STX) ? `SMB_ST_SL_STOP : `SMB_ST_BUS_ERR;
          end
          ph_r   <= PH_IDLE;
          mst_r  <= M_NONE;
          mas_r  <= 1'b0;
          msl_r  <= 1'b0;
          msda_r <= 1'b0;
          dlow_r <= 1'b0;
          bcnt_r <= 4'h0;
        end
        // The clock pulse of our own stop or repeated start carries no data bit
        else if (scl_rise && ph_r != PH_IDLE && mst_r != M_STOP && mst_r != M_RST)
        begin
          if (bcnt_r < 4'h8)
          begin
            // Bus bit shifts in on every byte, sent or received
            dat_r  <= {dat_r[6:0], sda_s};
            bcnt_r <= bcnt_r + 4'h1;
            if (mas_r && ph_r == PH_MTX && !dlow_r && !sda_s)
            begin
              // Released a one but the wire is low: another master won
              mas_r  <= 1'b0;
              mst_r  <= M_NONE;
              msl_r  <= 1'b0;
              lost_r <= 1'b1;
              ph_r   <= first_r ? PH_ADDR : PH_LOST;
            end
          end
          else
          begin
            ack_r  <= ~sda_s;
            bcnt_r <= 4'h9;
          end
        end
        else if (scl_fall && ph_r != PH_IDLE)
        begin
          msda_r <= 1'b0;
          if (bcnt_r == 4'h8)
          begin
            if (ph_r == PH_ADDR)
            begin
              // The own address register only matters as a slave
              if (aa_r && (own_hit || gc_hit))
              begin
                dlow_r <= 1'b1;
                gc_r   <= gc_hit & ~own_hit;
              end
              else
              begin
                dlow_r <= 1'b0;
                ph_r   <= lost_r ? PH_LOST : PH_IDLE;
              end
            end
            else if ((ph_r == PH_SRX) || (ph_r == PH_MRX))
              dlow_r <= aa_r;
            else
              dlow_r <= 1'b0;
          end
          else if (bcnt_r == 4'h9)
          begin
            dlow_r <= 1'b0;
            bcnt_r <= 4'h0;
            si_r   <= 1'b1;
            if (mas_r)
              mst_r <= M_WAIT;
            case (ph_r)
              PH_ADDR:
              begin
                lost_r <= 1'b0;
                if (dat_r[0])
                begin
                  ph_r   <= PH_STX;
                  stat_r <= lost_r ? `SMB_ST_ST_OWN_AL : `SMB_ST_ST_OWN;
                end
                else
                begin
                  ph_r   <= PH_SRX;
                  stat_r <= gc_r ? (lost_r ? `SMB_ST_SR_GC_AL : `SMB_ST_SR_GC)
                                 : (lost_r ? `SMB_ST_SR_OWN_AL : `SMB_ST_SR_OWN);
                end
              end
              PH_LOST:
              begin
                lost_r <= 1'b0;
                ph_r   <= PH_IDLE;
                stat_r <= `SMB_ST_ARB_LOST;
              end
              PH_SRX:
              begin
                stat_r <= gc_r ? (ack_r ? `SMB_ST_SR_GD_ACK : `SMB_ST_SR_GD_NAK)
                               : (ack_r ? `SMB_ST_SR_D_ACK : `SMB_ST_SR_D_NAK);
                if (!ack_r)
                  ph_r <= PH_IDLE;
              end
              PH_STX:
              begin
                stat_r <= !ack_r ? `SMB_ST_ST_D_NAK : (aa_r ? `SMB_ST_ST_D_ACK : `SMB_ST_ST_LAST);
                if (!ack_r || !aa_r)
                  ph_r <= PH_IDLE;
              end
              PH_MTX:
              begin
                first_r <= 1'b0;
                if (first_r)
                begin
                  stat_r <= dat_r[0] ? (ack_r ? `SMB_ST_MR_AR_ACK : `SMB_ST_MR_AR_NAK)
                                     : (ack_r ? `SMB_ST_MT_AW_ACK : `SMB_ST_MT_AW_NAK);
                  if (ack_r && dat_r[0])
                    ph_r <= PH_MRX;
                end
                else
                  stat_r <= ack_r ? `SMB_ST_MT_D_ACK : `SMB_ST_MT_D_NAK;
              end
              default:
                stat_r <= ack_r ? `SMB_ST_MR_D_ACK : `SMB_ST_MR_D_NAK;
            endcase
          end
          else
            dlow_r <= tx_ph & ~dat_r[7];
        end
        // Master sequencer
        case (mst_r)
          M_NONE:
          begin
            if (sta_r && !busy_r && !mas_r && ph_r == PH_IDLE && !si_r)
              mst_r <= M_START;
            else if (sto_r && !mas_r)
            begin
              // Slave recovery: act as if a stop was seen, bus stays busy
              sto_r  <= 1'b0;
              ph_r   <= PH_IDLE;
              dlow_r <= 1'b0;
            end
          end
          M_START:
          begin
            if (!msda_r && !mas_r && busy_r)
              mst_r <= M_NONE;
            else if (tmr_ovf && !msda_r)
              msda_r <= 1'b1;
            else if (tmr_ovf)
            begin
              msl_r   <= 1'b1;
              si_r    <= 1'b1;
              stat_r  <= mas_r ? `SMB_ST_RSTART : `SMB_ST_START;
              mas_r   <= 1'b1;
              ph_r    <= PH_MTX;
              first_r <= 1'b1;
              lost_r  <= 1'b0;
              bcnt_r  <= 4'h0;
              mst_r   <= M_WAIT;
            end
          end
          M_BYTE:
          begin
            if (msl_r && tmr_ovf)
              msl_r <= 1'b0;
            else if (!msl_r && scl_s && tmr_ovf)
              msl_r <= 1'b1;
          end
          M_STOP, M_RST:
          begin
            if (msl_r && tmr_ovf)
              msl_r <= 1'b0;
            else if (!msl_r && scl_s && tmr_ovf && mst_r == M_STOP)
              msda_r <= 1'b0;
            else if (!msl_r && scl_s && tmr_ovf)
              mst_r <= M_START;
          end
          default:
            mst_r <= mst_r;
        endcase
        // Flag cleared by software: load the first bit or pick the next master step
        if (si_clr && !scl_s)
        begin
          if (mas_r && mst_r == M_WAIT && sfr_wdata_in[`SMB_CTL_STO])
          begin
            mst_r  <= M_STOP;
            msda_r <= 1'b1;
            dlow_r <= 1'b0;
          end
          else if (mas_r && mst_r == M_WAIT && sfr_wdata_in[`SMB_CTL_STA])
          begin
            mst_r  <= M_RST;
            dlow_r <= 1'b0;
          end
          else
          begin
            if (mas_r && mst_r == M_WAIT)
              mst_r <= M_BYTE;
            if (bcnt_r == 4'h0)
              dlow_r <= tx_ph & ~dat_r[7];
          end
        end
      end
    end
  end

endmodule // smb_core

/* verilog/smb_map.vh */
`ifndef SMB_MAP_VH
`define SMB_MAP_VH

// Register addresses on the special function register port
`define SMB_ADR_CTRL      8'hc0
`define SMB_ADR_STAT      8'hc1
`define SMB_ADR_DATA      8'hc2
`define SMB_ADR_OWN       8'hc3
`define SMB_ADR_RATE      8'hcf

// Control register bit positions
`define SMB_CTL_BUSY      7
`define SMB_CTL_EN        6
`define SMB_CTL_STA       5
`define SMB_CTL_STO       4
`define SMB_CTL_SI        3
`define SMB_CTL_AA        2
`define SMB_CTL_FTE       1
`define SMB_CTL_TOE       0

// Reset values
`define SMB_RST_CTRL      8'h00
`define SMB_RST_OWN       8'h00
`define SMB_RST_RATE      8'h00
`define SMB_RST_DATA      8'h00
`define SMB_RST_STAT      8'hf8

// Status codes
`define SMB_ST_BUS_ERR    8'h00
`define SMB_ST_START      8'h08
`define SMB_ST_RSTART     8'h10
`define SMB_ST_MT_AW_ACK  8'h18
`define SMB_ST_MT_AW_NAK  8'h20
`define SMB_ST_MT_D_ACK   8'h28
`define SMB_ST_MT_D_NAK   8'h30
`define SMB_ST_ARB_LOST   8'h38
`define SMB_ST_MR_AR_ACK  8'h40
`define SMB_ST_MR_AR_NAK  8'h48
`define SMB_ST_MR_D_ACK   8'h50
`define SMB_ST_MR_D_NAK   8'h58
`define SMB_ST_SR_OWN     8'h60
`define SMB_ST_SR_OWN_AL  8'h68
`define SMB_ST_SR_GC      8'h70
`define SMB_ST_SR_GC_AL   8'h78
`define SMB_ST_SR_D_ACK   8'h80
`define SMB_ST_SR_D_NAK   8'h88
`define SMB_ST_SR_GD_ACK  8'h90
`define SMB_ST_SR_GD_NAK  8'h98
`define SMB_ST_SL_STOP    8'ha0
`define SMB_ST_ST_OWN     8'ha8
`define SMB_ST_ST_OWN_AL  8'hb0
`define SMB_ST_ST_D_ACK   8'hb8
`define SMB_ST_ST_D_NAK   8'hc0
`define SMB_ST_ST_LAST    8'hc8
`define SMB_ST_IDLE       8'hf8

// General call address
`define SMB_GC_ADDR       8'h00

`endif

/* sim/smb_core_props.sv */
`timescale 1ns/1ps
`include "smb_map.vh"
module smb_core_props
(
  // Clock, reset and register port
  input wire       ref_clk_in,
  input wire       rst_in,
  input wire [7:0] sfr_addr_in,
  input wire       sfr_wr_in,
  input wire [7:0] sfr_wdata_in,
  input wire [7:0] sfr_rdata_out,
  // Bus pins, event flag, timer steering
  input wire       scl_in,
  input wire       scl_drv_out,
  input wire       scl_oe_n_out,
  input wire       sda_in,
  input wire       sda_drv_out,
  input wire       sda_oe_n_out,
  input wire       si_flag_out,
  input wire       t3_reload_out,
  input wire       t3_count_out
);
  reg  [7:0] own_r;
  reg        toe_r;
  wire       ctl_wr = sfr_wr_in && sfr_addr_in == `SMB_ADR_CTRL;
  // Shadows of software-written fields
  always @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      own_r <= 8'h00;
      toe_r <= 1'b0;
    end
    else
    begin
      if (sfr_wr_in && sfr_addr_in == `SMB_ADR_OWN)
        own_r <= sfr_wdata_in;
      if (ctl_wr)
        toe_r <= sfr_wdata_in[0];
    end
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  // A control write may clear the flag, so only other cycles must keep it
  si_hold_a: assert property (si_flag_out && !ctl_wr |=> si_flag_out)
    else $error("event flag dropped without software");
  scl_stretch_a: assert property ((si_flag_out && !scl_in) [*6] |-> !scl_oe_n_out)
    else $error("low clock not held while flag set");
  scl_keep_a: assert property (
    si_flag_out && !scl_oe_n_out && !ctl_wr |=> !scl_oe_n_out)
    else $error("clock hold let go early");
  // A master still ends its own clock-low half, eight cycles at the bench rate
  si_release_a: assert property ($fell(si_flag_out) |-> ##[0:12] scl_oe_n_out)
    else $error("clock not released after flag clear");
  // Sync stages add latency, hence the run of equal samples first
  t3_high_a: assert property (
    (toe_r && scl_in) [*5] |-> t3_reload_out && !t3_count_out)
    else $error("timer not reloading with clock high");
  t3_low_a: assert property (
    (toe_r && !scl_in) [*5] |-> t3_count_out && !t3_reload_out)
    else $error("timer not counting with clock low");
  t3_off_a: assert property (!toe_r [*3] |-> !t3_reload_out && !t3_count_out)
    else $error("timer steering without enable");
  rd_own_a: assert property (
    sfr_addr_in == `SMB_ADR_OWN && !sfr_wr_in |=> sfr_rdata_out == $past(own_r))
    else $error("own address readback wrong");
  // Open drain: the drive values never leave low, only the enables move
  pin_drive_a: assert property (!scl_drv_out && !sda_drv_out)
    else $error("pin drive value not low");
  rd_unmap_a: assert property (sfr_addr_in[7:4] != 4'hc |=> sfr_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  cover property ($rose(si_flag_out));
  cover property ($fell(sda_oe_n_out) && !si_flag_out);
  cover property ((toe_r && !scl_in) [*5]);
endmodule // smb_core_props
bind smb_core smb_core_props u_props (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in),
  .sfr_rdata_out(sfr_rdata_out), .scl_in(scl_in), .scl_drv_out(scl_drv_out),
  .scl_oe_n_out(scl_oe_n_out), .sda_in(sda_in), .sda_drv_out(sda_drv_out),
  .sda_oe_n_out(sda_oe_n_out), .si_flag_out(si_flag_out),
  .t3_reload_out(t3_reload_out), .t3_count_out(t3_count_out));

/* sim/smb_bus_model.sv */
`timescale 1ns/1ps
module smb_bus_model
(
  // Wire levels seen on the bus
  input  wire scl_in,
  input  wire sda_in,
  // Open-drain releases, 1 lets the pull-up win
  output reg  scl_rel_out,
  output reg  sda_rel_out
);
  localparam real QTR = 31.25;
  integer n;
  initial
  begin
    scl_rel_out = 1'b1;
    sda_rel_out = 1'b1;
  end
  // Data changes only while clock low; a stretching slave is waited for
  task bit_cyc(input v, output s);
  begin
    sda_rel_out = v;
    #QTR scl_rel_out = 1'b1;
    n = 0;
    while (!scl_in && n < 4000)
    begin
      #5 n = n + 1;
    end
    #QTR s = sda_in;
    #QTR scl_rel_out = 1'b0;
    #QTR;
  end
  endtask
  // Clock stands high between frames
  task start_c;
  begin
    sda_rel_out = 1'b0;
    #(2*QTR) scl_rel_out = 1'b0;
    #(2*QTR);
  end
  endtask
  task stop_c;
  begin
    sda_rel_out = 1'b0;
    #QTR scl_rel_out = 1'b1;
    #(2*QTR) sda_rel_out = 1'b1;
    #(2*QTR);
  end
  endtask
  task send_byte(input [7:0] b, output ack);
    integer i;
    reg     s;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bit_cyc(b[i], s);
    bit_cyc(1'b1, s);
    ack = !s;
  end
  endtask
  task recv_byte(output [7:0] b, input ack);
    integer i;
    reg     s;
  begin
    for (i = 7; i >= 0; i = i - 1)
      bit_cyc(1'b1, b[i]);
    bit_cyc(!ack, s);
  end
  endtask
endmodule // smb_bus_model

/* sim/tb_smbus_data_address_control.sv */
`timescale 1ns/1ps
`include "smb_map.vh"
module tb_smbus_data_address_control;
  reg        ref_clk_in;
  reg        rst_in;
  reg  [7:0] sfr_addr_in;
  reg        sfr_wr_in;
  reg  [7:0] sfr_wdata_in;
  wire [7:0] sfr_rdata_out;
  wire       scl_oe_n, sda_oe_n, si_flag, scl_rel, sda_rel;
  // Open drain with pull-ups: low if any party pulls
  wire       scl_w = scl_rel & scl_oe_n;
  wire       sda_w = sda_rel & sda_oe_n;
  integer    err_total, check_count, i, k;
  reg [31:0] rng;
  reg [7:0]  rd, own, ad, exp_st, d, b;
  reg        ack, gc, aa;

  always #2.5 ref_clk_in = ~ref_clk_in;

  smb_core DUT (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .sfr_addr_in(sfr_addr_in),
    .sfr_wr_in(sfr_wr_in), .sfr_wdata_in(sfr_wdata_in), .sfr_rdata_out(sfr_rdata_out),
    .scl_in(scl_w), .scl_drv_out(), .scl_oe_n_out(scl_oe_n), .sda_in(sda_w),
    .sda_drv_out(), .sda_oe_n_out(sda_oe_n), .si_flag_out(si_flag),
    .t3_reload_out(), .t3_count_out());
  smb_bus_model bus (.scl_in(scl_w), .sda_in(sda_w), .scl_rel_out(scl_rel),
    .sda_rel_out(sda_rel));

  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
  begin
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xs = y ^ (y << 5);
  end
  endfunction
  // Reference model of address recognition: f8 means no acknowledge
  function [7:0] exp_addr(input [7:0] a, input [7:0] o, input f);
  begin
    if (!f)
      exp_addr = 8'hf8;
    else if (a[7:1] == o[7:1] && o[7:1] != 7'h00)
      exp_addr = a[0] ? 8'ha8 : 8'h60;
    else if (a == 8'h00 && o[0])
      exp_addr = 8'h70;
    else
      exp_addr = 8'hf8;
  end
  endfunction
  task check(input [7:0] seen, input [7:0] expv);
  begin
    check_count = check_count + 1;
    if (seen !== expv)
    begin
      err_total = err_total + 1;
      $display("Error at %0t: saw %h expected %h", $time, seen, expv);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] v);
  begin
    @(negedge ref_clk_in) sfr_addr_in = a;
    sfr_wdata_in = v;
    sfr_wr_in = 1'b1;
    @(negedge ref_clk_in) sfr_wr_in = 1'b0;
  end
  endtask
  task rdr(input [7:0] a, output [7:0] v);
  begin
    @(negedge ref_clk_in) sfr_addr_in = a;
    @(negedge ref_clk_in) v = sfr_rdata_out;
  end
  endtask
  task wait_si;
  begin
    k = 0;
    while (si_flag !== 1'b1 && k < 2000)
    begin
      @(posedge ref_clk_in) k = k + 1;
    end
    check({7'h00, si_flag}, 8'h01);
  end
  endtask
  task report_and_stop;
  begin
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end
  endtask

  // Watchdog well beyond the eight frames of traffic
  initial
  begin
    #300000;
    err_total = err_total + 1;
    report_and_stop;
  end

  initial
  begin
    ref_clk_in = 1'b0;
    rst_in = 1'b1;
    sfr_addr_in = 8'h00;
    sfr_wr_in = 1'b0;
    sfr_wdata_in = 8'h00;
    err_total = 0;
    check_count = 0;
    rng = 32'hcf4c;
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in) rst_in = 1'b0;
    // Reset values, a read-only place and an unmapped one
    rdr(`SMB_ADR_CTRL, rd); check(rd, 8'h00);
    rdr(`SMB_ADR_OWN, rd); check(rd, 8'h00);
    wr(`SMB_ADR_STAT, 8'h3c);
    rdr(`SMB_ADR_STAT, rd); check(rd, 8'hf8);
    rdr(8'h5a, rd); check(rd, 8'h00);
    check({7'h00, si_flag}, 8'h00);
    // Cases: own W, gc on, gc off, top bit flipped, ack off, own R, own W with gc
    for (i = 0; i < 7; i = i + 1)
    begin
      rng = xs(rng);
      gc = (i == 1 || i == 6);
      aa = (i != 4);
      own = {rng[6:0] % 7'd126 + 7'd1, gc};
      ad = (i == 1 || i == 2) ? 8'h00 : (i == 3) ? (own & 8'hfe) ^ 8'h80 :
           (i == 5) ? own | 8'h01 : own & 8'hfe;
      wr(`SMB_ADR_OWN, own);
      rdr(`SMB_ADR_OWN, rd); check(rd, own);
      wr(`SMB_ADR_CTRL, aa ? 8'h45 : 8'h41);
      exp_st = exp_addr(ad, own, aa);
      bus.start_c;
      bus.send_byte(ad, ack);
      check({7'h00, ack}, {7'h00, exp_st != 8'hf8});
      if (exp_st != 8'hf8)
      begin
        wait_si;
        rdr(`SMB_ADR_STAT, rd); check(rd, exp_st);
        d = rng[15:8];
        if (ad[0])
        begin
          wr(`SMB_ADR_DATA, d);
          wr(`SMB_ADR_CTRL, 8'h45);
          bus.recv_byte(b, 1'b0);
          check(b, d);
          wait_si;
          rdr(`SMB_ADR_STAT, rd); check(rd, 8'hc0);
          rdr(`SMB_ADR_DATA, rd); check(rd, d);
        end
        else
        begin
          wr(`SMB_ADR_CTRL, 8'h45);
          bus.send_byte(d, ack);
          check({7'h00, ack}, 8'h01);
          wait_si;
          rdr(`SMB_ADR_STAT, rd); check(rd, (ad == 8'h00) ? 8'h90 : 8'h80);
          rdr(`SMB_ADR_DATA, rd); check(rd, d);
        end
        wr(`SMB_ADR_CTRL, 8'h45);
      end
      bus.stop_c;
      repeat (8) @(posedge ref_clk_in);
      if (exp_st == 8'h60 || exp_st == 8'h70)
      begin
        wait_si;
        rdr(`SMB_ADR_STAT, rd); check(rd, 8'ha0);
      end
      // Clear any leftover flag so the next frame starts clean
      if (si_flag === 1'b1)
        wr(`SMB_ADR_CTRL, 8'h45);
    end
    // Master: our own address sent as master must not be answered by ourselves
    wr(`SMB_ADR_RATE, 8'hf8);
    wr(`SMB_ADR_CTRL, 8'h65);
    wait_si;
    rdr(`SMB_ADR_STAT, rd);
    check(rd, 8'h08);
    wr(`SMB_ADR_DATA, own & 8'hfe);
    wr(`SMB_ADR_CTRL, 8'h45);
    wait_si;
    rdr(`SMB_ADR_STAT, rd);
    check(rd, 8'h20);
    rdr(`SMB_ADR_DATA, rd);
    check(rd, own & 8'hfe);
    // Our own stop must clear the stop request and free the bus
    wr(`SMB_ADR_CTRL, 8'h55);
    repeat (40) @(posedge ref_clk_in);
    rdr(`SMB_ADR_CTRL, rd);
    check(rd, 8'h45);
    report_and_stop;
  end
endmodule // tb_smbus_data_address_control
